// [rtl/alu_pkg.sv]
// package: opcodes, flag positions, reset values and carriers for the alu block
package alu_pkg;
   localparam int DATA_W = 8;
   localparam logic [3:0] NIBBLE_MAX = 4'h9;
   localparam logic [3:0] NIBBLE_FIX = 4'h6;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] ONE = 8'h01;
   localparam int WATCHDOG_W = 16;
   localparam logic [15:0] WATCHDOG_RST = 16'h0000;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam int MEM_AW = 4;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_CPLA,
      OP_ADJUST,
      OP_SUB_MEM,
      OP_SUB_ACC,
      OP_HALT,
      OP_INC,
      OP_INCA
   } op_t;

   // instruction request with its operand address
   typedef struct packed {
      logic valid;
      op_t op;
      logic [3:0] addr;
   } req_t;

   // status flags held by the block
   typedef struct packed {
      logic carry;
      logic nibble_half_flag;
      logic zero;
      logic sleep_entered_flag;
      logic watchdog_expiry_flag;
   } flags_t;
endpackage

// [rtl/alu_data_mem.sv]
// small data memory with registered read port
`timescale 1ns/100ps
module alu_data_mem (
   // clock
   input wire logic clk_sys,
   // write port
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:15];

   // no reset on storage: contents survive sleep and reset alike
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// [rtl/alu_incdec_bcd.sv]
// execution datapath for complement, decimal adjust, increment and sleep
// ***************************************************************
// Notes on behaviour
// - complement takes the inverted operand into acc, memory kept, zero updated.
// - decimal adjust adds 6 to the low nibble if above 9 or half flag set.
// - decimal adjust adds 6 to the high nibble if above 9 or carry set.
// - decimal adjust writes acc plus 00/06/60/66 hex to memory, not acc.
// - decimal adjust changes only carry, set when the sum passes 99.
// - memory decrement writes operand minus one back and updates zero.
// - decrement to acc puts operand minus one in acc, memory kept.
// - sleep stops execution and gates the system clock off.
// - sleep keeps all memory and the acc contents.
// - sleep clears the watchdog timer and its prescaler.
// - sleep sets the sleep flag and clears the expiry flag only.
// - memory increment writes operand plus one back and updates zero.
// - increment to acc puts operand plus one in acc, memory kept.
// ***************************************************************
`timescale 1ns/100ps
module alu_incdec_bcd (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // instruction request
   input wire alu_pkg::req_t req,
   // flag, acc and memory preload, wake and watchdog tick
   input wire logic flags_load,
   input wire alu_pkg::flags_t flags_in,
   input wire logic acc_load,
   input wire logic [7:0] acc_in,
   input wire logic mem_load,
   input wire logic [3:0] mem_load_addr,
   input wire logic [7:0] mem_load_data,
   input wire logic wake,
   input wire logic watchdog_tick,
   // results
   output logic [7:0] acc,
   output alu_pkg::flags_t flags,
   output logic [7:0] mem_rd_data,
   output logic done,
   output logic busy,
   output logic sleeping,
   output logic sys_clk_en,
   output logic [15:0] watchdog_timer
);
   // ***************************************************************
   // state machine
   // ***************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_SLEEP} st_t;
   st_t state_reg, state_next;
   alu_pkg::req_t cur_reg;
   logic [7:0] acc_reg;
   alu_pkg::flags_t flags_reg;
   logic done_reg;
   logic [15:0] watchdog_reg;
   logic [7:0] presc_reg;
   logic [7:0] operand;
   logic [7:0] mem_q;

   // decode used for the write-back choice between memory and acc
   function automatic logic to_mem(input alu_pkg::op_t op);
      to_mem = (op == alu_pkg::OP_ADJUST) || (op == alu_pkg::OP_SUB_MEM) ||
               (op == alu_pkg::OP_INC);
   endfunction

   // ***************************************************************
   // datapath
   // ***************************************************************
   wire logic [7:0] inv_res = ~operand;
   wire logic [7:0] sub_res = operand - alu_pkg::ONE;
   wire logic [7:0] inc_res = operand + alu_pkg::ONE;
   wire logic lo_fix = (acc_reg[3:0] > alu_pkg::NIBBLE_MAX) ||
                       flags_reg.nibble_half_flag;
   wire logic [4:0] lo_sum = {1'b0, acc_reg[3:0]} +
                             {1'b0, (lo_fix ? alu_pkg::NIBBLE_FIX : 4'h0)};
   // high nibble test sees the low-nibble carry, as a decimal sum must
   wire logic [4:0] hi_base = {1'b0, acc_reg[7:4]} + {4'h0, lo_sum[4]};
   wire logic hi_fix = (hi_base > {1'b0, alu_pkg::NIBBLE_MAX}) ||
                       flags_reg.carry;
   wire logic [4:0] hi_sum = hi_base +
                             {1'b0, (hi_fix ? alu_pkg::NIBBLE_FIX : 4'h0)};
   wire logic [7:0] adjust_res = {hi_sum[3:0], lo_sum[3:0]};
   wire logic adjust_carry = hi_sum[4] | flags_reg.carry;

   logic [7:0] result;
   always_comb begin
      case (cur_reg.op)
         alu_pkg::OP_CPLA: result = inv_res;
         alu_pkg::OP_ADJUST: result = adjust_res;
         alu_pkg::OP_SUB_MEM, alu_pkg::OP_SUB_ACC: result = sub_res;
         alu_pkg::OP_INC, alu_pkg::OP_INCA: result = inc_res;
         default: result = operand;
      endcase
   end

   wire logic exec = (state_reg == ST_EXEC);
   wire logic is_halt = exec && (cur_reg.op == alu_pkg::OP_HALT);
   wire logic wr_mem = exec && to_mem(cur_reg.op);
   wire logic wr_acc = exec && !to_mem(cur_reg.op) &&
                       (cur_reg.op != alu_pkg::OP_HALT) &&
                       (cur_reg.op != alu_pkg::OP_NONE);
   wire logic upd_zero = exec && (cur_reg.op != alu_pkg::OP_ADJUST) &&
                         (cur_reg.op != alu_pkg::OP_HALT) &&
                         (cur_reg.op != alu_pkg::OP_NONE);
   // loads land only in idle, so they never race a write-back
   wire logic mem_we = wr_mem || (mem_load && state_reg == ST_IDLE);
   wire logic [3:0] mem_wa = wr_mem ? cur_reg.addr : mem_load_addr;
   wire logic [7:0] mem_wd = wr_mem ? result : mem_load_data;
   wire logic [3:0] mem_ra = (state_reg == ST_IDLE) ? req.addr : cur_reg.addr;
   assign operand = mem_q;

   alu_data_mem u_mem (
      .clk_sys(clk_sys),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd),
      .rd_addr(mem_ra),
      .rd_data(mem_q)
   );

   // ***************************************************************
   // sequencing
   // ***************************************************************
   // a valid held past idle is taken again as a new request
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (req.valid) state_next = ST_READ;
         ST_READ: state_next = ST_EXEC;
         ST_EXEC: state_next = is_halt ? ST_SLEEP : ST_IDLE;
         ST_SLEEP: if (wake) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         cur_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg <= exec;
         if (state_reg == ST_IDLE && req.valid) begin
            cur_reg <= req;
         end
      end
   end

   // acc and flags hold through sleep: nothing writes them there
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         acc_reg <= alu_pkg::ACC_RST;
         flags_reg <= '0;
      end else begin
         if (wr_acc) begin
            acc_reg <= result;
         end else if (acc_load && state_reg == ST_IDLE) begin
            acc_reg <= acc_in;
         end
         if (flags_load && state_reg == ST_IDLE) begin
            flags_reg <= flags_in;
         end
         if (upd_zero) begin
            flags_reg.zero <= (result == 8'h00);
         end
         if (exec && cur_reg.op == alu_pkg::OP_ADJUST) begin
            flags_reg.carry <= adjust_carry;
         end
         if (is_halt) begin
            flags_reg.sleep_entered_flag <= 1'b1;
            flags_reg.watchdog_expiry_flag <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // watchdog and prescaler
   // ***************************************************************
   // prescaler wrap carries one count into the timer
   always_ff @(posedge clk_sys) begin
      if (sys_rst || is_halt) begin
         presc_reg <= alu_pkg::PRESC_RST;
         watchdog_reg <= alu_pkg::WATCHDOG_RST;
      end else if (watchdog_tick) begin
         presc_reg <= presc_reg + 8'h01;
         if (presc_reg == 8'hff) begin
            watchdog_reg <= watchdog_reg + 16'h0001;
         end
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // busy, sleep and clock enable built from state_next so each lines up with the state
   logic busy_reg, sleep_reg, clk_en_reg;
   logic [7:0] mem_out_reg;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         busy_reg <= 1'b0;
         sleep_reg <= 1'b0;
         clk_en_reg <= 1'b1;
         mem_out_reg <= 8'h00;
      end else begin
         busy_reg <= (state_next == ST_READ) || (state_next == ST_EXEC);
         sleep_reg <= (state_next == ST_SLEEP);
         clk_en_reg <= (state_next != ST_SLEEP);
         mem_out_reg <= mem_q;
      end
   end

   assign acc = acc_reg;
   assign flags = flags_reg;
   assign done = done_reg;
   assign busy = busy_reg;
   assign sleeping = sleep_reg;
   assign sys_clk_en = clk_en_reg;
   assign watchdog_timer = watchdog_reg;
   assign mem_rd_data = mem_out_reg;
endmodule

// [dv/alu_incdec_bcd_props.sv]
// checker: timing and flag relations of the alu datapath
`timescale 1ns/100ps
module alu_incdec_bcd_props (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire alu_pkg::req_t req,
   input wire logic [7:0] acc,
   input wire alu_pkg::flags_t flags,
   input wire logic done,
   input wire logic busy,
   input wire logic sleeping,
   input wire logic sys_clk_en,
   input wire logic [15:0] watchdog_timer
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic take;
   alu_pkg::op_t op_reg;
   assign take = req.valid && !busy && !sleeping;
   // op kept so the flag check knows the destination at done
   always_ff @(posedge clk_sys) begin
      if (take) op_reg <= req.op;
   end
   sequence s_exec;
      busy ##1 busy ##1 (done && !busy);
   endsequence
   a_exec_timing: assert property (take && req.op != alu_pkg::OP_HALT
      |=> s_exec) else $error("exec timing wrong");
   a_zero_match: assert property (done && op_reg inside {alu_pkg::OP_CPLA,
      alu_pkg::OP_SUB_ACC, alu_pkg::OP_INCA} |-> flags.zero == (acc == 8'h00))
      else $error("zero flag wrong");
   a_adjust_acc_kept: assert property (take
      && req.op == alu_pkg::OP_ADJUST |=> $stable(acc) [*3])
      else $error("adjust changed acc");
   a_adjust_carry_only: assert property (take
      && req.op == alu_pkg::OP_ADJUST
      |=> ($stable(flags[3:0]) && !$fell(flags.carry)) [*3])
      else $error("adjust touched other flags");
   a_zero_only: assert property (take && req.op inside {alu_pkg::OP_INC,
      alu_pkg::OP_SUB_MEM, alu_pkg::OP_CPLA, alu_pkg::OP_INCA,
      alu_pkg::OP_SUB_ACC} |=> $stable({flags[4:3], flags[1:0]}) [*3])
      else $error("flags moved");
   a_halt_entry: assert property (take && req.op == alu_pkg::OP_HALT
      |-> ##[1:3] (sleeping && flags.sleep_entered_flag
      && !flags.watchdog_expiry_flag && watchdog_timer == 16'h0000))
      else $error("sleep entry wrong");
   a_clk_gated: assert property (sleeping |-> !sys_clk_en)
      else $error("clock runs in sleep");
   a_sleep_keep: assert property (sleeping && $past(sleeping)
      |-> $stable(acc) && $stable(flags)) else $error("state lost in sleep");
endmodule
bind alu_incdec_bcd alu_incdec_bcd_props u_props (.clk_sys, .sys_rst, .req,
   .acc, .flags, .done, .busy, .sleeping, .sys_clk_en, .watchdog_timer);

// [dv/test_mcu_alu_incdec_bcd_halt.sv]
// testbench: random and boundary operations with queued expectations
`timescale 1ns/100ps
module test_mcu_alu_incdec_bcd_halt;
   logic clk_sys = 1'b0, sys_rst = 1'b1, flags_load = 1'b0, acc_load = 1'b0;
   logic mem_load = 1'b0, wake = 1'b0, watchdog_tick = 1'b0;
   logic done, busy, sleeping, sys_clk_en;
   logic [3:0] mem_load_addr = 4'h0;
   logic [7:0] acc_in = 8'h00, mem_load_data = 8'h00, acc, ma, mem_rd;
   logic [7:0] m [16];
   logic [15:0] watchdog_timer;
   alu_pkg::req_t req = '0;
   alu_pkg::flags_t flags_in = '0, flags, mf;
   logic [12:0] q [$];
   int bad_count = 0, num_checks = 0, seed = 74;
   alu_pkg::op_t ops [7] = '{alu_pkg::OP_CPLA, alu_pkg::OP_ADJUST,
      alu_pkg::OP_SUB_MEM, alu_pkg::OP_SUB_ACC, alu_pkg::OP_INC,
      alu_pkg::OP_INCA, alu_pkg::OP_NONE};
   logic [7:0] bnd [4] = '{8'h00, 8'h01, 8'hff, 8'h99};
   alu_incdec_bcd DUT (.clk_sys, .sys_rst, .req, .flags_load, .flags_in,
      .acc_load, .acc_in, .mem_load, .mem_load_addr, .mem_load_data, .wake,
      .watchdog_tick, .acc, .flags, .mem_rd_data(mem_rd), .done, .busy,
      .sleeping,
      .sys_clk_en, .watchdog_timer);
   always #50 clk_sys = ~clk_sys;
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      num_checks++;
      if (e !== s) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // results are compared only when done shows, oldest note first
   always @(posedge clk_sys) begin
      if (done === 1'b1) begin
         chk("result", 16'(q.pop_front()), 16'({acc, flags}));
      end
   end
   task automatic run(alu_pkg::op_t o, logic [3:0] ad);
      logic [7:0] v;
      logic [8:0] s;
      v = m[ad];
      case (o)
         alu_pkg::OP_CPLA: ma = ~v;
         alu_pkg::OP_SUB_ACC: ma = v - 8'h01;
         alu_pkg::OP_INCA: ma = v + 8'h01;
         alu_pkg::OP_SUB_MEM: m[ad] = v - 8'h01;
         alu_pkg::OP_INC: m[ad] = v + 8'h01;
         alu_pkg::OP_ADJUST: begin
            s = {1'b0, ma};
            if (ma[3:0] > 4'h9 || mf.nibble_half_flag) s = s + 9'h006;
            if (s[7:4] > 4'h9 || mf.carry || s[8]) s = s + 9'h060;
            m[ad] = s[7:0];
            mf.carry = mf.carry | s[8];
         end
         default: ;
      endcase
      if (!(o inside {alu_pkg::OP_ADJUST, alu_pkg::OP_NONE})) begin
         mf.zero = ((o == alu_pkg::OP_SUB_MEM || o == alu_pkg::OP_INC) ?
            m[ad] : ma) == 8'h00;
      end
      q.push_back({ma, mf});
      req <= '{1'b1, o, ad};
      @(posedge clk_sys);
      req.valid <= 1'b0;
      // read data trails the idle address by two edges
      cyc(5);
      chk("memory", 16'(m[ad]), 16'(mem_rd));
   endtask
   task burst(int n);
      logic [31:0] k;
      repeat (n) begin
         k = $random(seed);
         mem_load <= 1'b1; acc_load <= 1'b1; flags_load <= 1'b1;
         mem_load_addr <= k[3:0];
         m[k[3:0]] = (k[12:11] == 2'h0) ? bnd[k[14:13]] : k[31:24];
         mem_load_data <= m[k[3:0]];
         ma = 8'($random(seed));
         mf = 5'($random(seed));
         acc_in <= ma; flags_in <= mf; watchdog_tick <= k[15];
         @(posedge clk_sys);
         mem_load <= 1'b0; acc_load <= 1'b0; flags_load <= 1'b0;
         run(ops[k[10:8] % 3'd7], k[3:0]);
         run(alu_pkg::OP_CPLA, k[3:0]);
      end
   endtask
   initial begin
      cyc(12);
      sys_rst <= 1'b0;
      burst(100);
      // enough ticks to wrap the prescaler twice before sleeping
      watchdog_tick <= 1'b1;
      cyc(600);
      watchdog_tick <= 1'b0;
      // sleep entry also raises done, so it gets a note of its own
      mf.sleep_entered_flag = 1'b1; mf.watchdog_expiry_flag = 1'b0;
      q.push_back({ma, mf});
      req <= '{1'b1, alu_pkg::OP_HALT, 4'h0};
      @(posedge clk_sys);
      req.valid <= 1'b0;
      cyc(5);
      acc_load <= 1'b1; acc_in <= ~ma;
      @(posedge clk_sys);
      acc_load <= 1'b0;
      cyc(3);
      chk("sleep", 16'h0002, 16'({sleeping, sys_clk_en}));
      chk("acc", 16'(ma), 16'(acc));
      chk("watchdog", 16'h0000, watchdog_timer);
      chk("flags", 16'(mf), 16'(flags));
      wake <= 1'b1;
      @(posedge clk_sys);
      wake <= 1'b0;
      cyc(2);
      burst(40);
      summarize();
   end
   initial begin
      cyc(8000);
      bad_count++;
      summarize();
   end
endmodule
